// *** logic/pph_periph.sv ***
// pph_periph: peripheral end of a parallel printer port, forward bytes and nibble reverse.
// assumes host pins are asynchronous to clock; user side runs on clock.
// Operation
// - in forward transfers the peripheral pulses acknowledge low to confirm a taken byte.
// - in reverse transfers acknowledge low qualifies each nibble on the status lines.
// - in forward transfers busy stays high while no byte can be taken.
// - in reverse transfers busy carries returned bit 3, then bit 7.
// - in forward transfers paper_fault high reports a paper path problem.
// - in reverse transfers paper_fault carries returned bit 2, then bit 6.
// - in forward transfers the online line reports that the peripheral is selected.
// - in reverse transfers the online line carries returned bit 1, then bit 5.
// - in forward transfers fault_n low reports an error.
// - in reverse transfers fault_n low means data ready and it carries bits 0 and 4.
`timescale 1ns/100ps
module pph_periph #(
  parameter int DEPTH = pph_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  // host pins
  input wire logic strobe_n,
  input wire logic [pph_pkg::BYTE_W-1:0] fwd_data,
  input wire logic line_feed_req_n,
  input wire logic periph_reset_n,
  input wire logic select_in_n,
  output logic ack_n,
  output logic busy,
  output logic paper_fault,
  output logic online,
  output logic fault_n,
  // user side
  output logic [pph_pkg::BYTE_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [pph_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic paper_fault_in,
  input wire logic online_in,
  input wire logic error_in,
  output logic auto_feed,
  output logic reverse_mode,
  output logic host_reset
);
  import pph_pkg::*;

  localparam int SW = BYTE_W + 4;

  // two-stage synchronisers; only stage two is read
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic strobe_prev_q;
  logic [BYTE_W-1:0] s_data;
  logic s_strobe_n;
  logic s_lf_n;
  logic s_init_n;
  logic s_sel_n;
  logic strobe_fall;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= {SW{1'b1}};
      sync2_q <= {SW{1'b1}};
      strobe_prev_q <= 1'b1;
    end else begin
      sync1_q <= {strobe_n, line_feed_req_n, periph_reset_n, select_in_n, fwd_data};
      sync2_q <= sync1_q;
      strobe_prev_q <= s_strobe_n;
    end
  end

  assign {s_strobe_n, s_lf_n, s_init_n, s_sel_n, s_data} = sync2_q;
  // only honour strobe in forward direction
  assign strobe_fall = strobe_prev_q && !s_strobe_n && !s_sel_n;

  // forward handshake state, declared ahead of the fifo push that reads it
  pph_fwd_e fwd_st_q;
  logic [CNT_W-1:0] fwd_cnt_q;
  logic fwd_ack_q;

  // receive fifo; pin side stalls through busy
  logic fifo_in_ready;
  logic fifo_push;
  logic [BYTE_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic fifo_out_ready;

  pph_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .in_data(s_data),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // output stage keeps rx_data and rx_valid on flops; it holds one word beyond the fifo
  assign fifo_out_ready = !rx_valid || rx_ready;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
    end else if (fifo_out_ready) begin
      rx_valid <= fifo_out_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_data <= '0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      rx_data <= fifo_out_data;
    end
  end

  // a byte strobed while full is dropped; busy was high, so the host broke handshake
  // a strobe seen while the host holds reset is not stored either
  assign fifo_push = strobe_fall && s_init_n && (fwd_st_q == PPH_F_IDLE);

  // forward handshake

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fwd_st_q <= PPH_F_IDLE;
      fwd_cnt_q <= '0;
      fwd_ack_q <= 1'b0;
    end else if (!s_init_n || s_sel_n) begin
      fwd_st_q <= PPH_F_IDLE;
      fwd_cnt_q <= '0;
      fwd_ack_q <= 1'b0;
    end else begin
      case (fwd_st_q)
        PPH_F_IDLE: begin
          if (strobe_fall) begin
            fwd_st_q <= PPH_F_ACK;
            fwd_cnt_q <= ACK_PULSE_CYC;
            fwd_ack_q <= 1'b1;
          end
        end
        PPH_F_ACK: begin
          if (fwd_cnt_q == 1) begin
            fwd_ack_q <= 1'b0;
            fwd_st_q <= PPH_F_DONE;
          end
          fwd_cnt_q <= fwd_cnt_q - 1'b1;
        end
        PPH_F_DONE: begin
          // wait for strobe release so one pulse is one byte
          if (s_strobe_n) begin
            fwd_st_q <= PPH_F_IDLE;
          end
        end
        default: fwd_st_q <= PPH_F_IDLE;
      endcase
    end
  end

  // reverse nibble transfer
  pph_rev_e rev_st_q;
  logic [CNT_W-1:0] rev_cnt_q;
  logic [BYTE_W-1:0] rev_byte_q;
  logic rev_hi_q;
  logic rev_ack_q;
  logic tx_take;
  logic [NIB_W-1:0] nib;

  assign tx_take = (rev_st_q == PPH_R_IDLE) && s_sel_n && s_init_n && !s_lf_n && tx_valid;
  assign nib = rev_hi_q ? rev_byte_q[BYTE_W-1:NIB_W] : rev_byte_q[NIB_W-1:0];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rev_st_q <= PPH_R_IDLE;
      rev_cnt_q <= '0;
      rev_byte_q <= '0;
      rev_hi_q <= 1'b0;
      rev_ack_q <= 1'b0;
    end else if (!s_init_n || !s_sel_n) begin
      rev_st_q <= PPH_R_IDLE;
      rev_hi_q <= 1'b0;
      rev_ack_q <= 1'b0;
    end else begin
      case (rev_st_q)
        PPH_R_IDLE: begin
          if (tx_take) begin
            rev_byte_q <= tx_data;
            rev_hi_q <= 1'b0;
            rev_cnt_q <= NIB_SETUP_CYC;
            rev_st_q <= PPH_R_SETUP;
          end
        end
        PPH_R_SETUP: begin
          // nibble settles on the status lines before ack falls
          if (rev_cnt_q == 1) begin
            rev_ack_q <= 1'b1;
            rev_st_q <= PPH_R_ACK;
          end
          rev_cnt_q <= rev_cnt_q - 1'b1;
        end
        PPH_R_ACK: begin
          if (s_lf_n) begin
            rev_ack_q <= 1'b0;
            rev_st_q <= rev_hi_q ? PPH_R_IDLE : PPH_R_REL;
          end
        end
        PPH_R_REL: begin
          // host lowers line feed again when ready for the high nibble
          if (!s_lf_n) begin
            rev_hi_q <= 1'b1;
            rev_cnt_q <= NIB_SETUP_CYC;
            rev_st_q <= PPH_R_SETUP;
          end
        end
        default: rev_st_q <= PPH_R_IDLE;
      endcase
    end
  end

  // pin outputs, all registered
  logic busy_d;
  logic paper_d;
  logic online_d;
  logic fault_n_d;
  logic ack_n_d;

  always_comb begin
    if (s_sel_n) begin
      ack_n_d = !rev_ack_q;
      if (rev_st_q == PPH_R_IDLE) begin
        fault_n_d = !tx_valid;
        busy_d = 1'b0;
        paper_d = 1'b0;
        online_d = 1'b0;
      end else begin
        fault_n_d = nib[NIB_FAULT_BIT];
        online_d = nib[NIB_ONLINE_BIT];
        paper_d = nib[NIB_PAPER_BIT];
        busy_d = nib[NIB_BUSY_BIT];
      end
    end else begin
      ack_n_d = !fwd_ack_q;
      busy_d = (fwd_st_q != PPH_F_IDLE) || !fifo_in_ready || !s_init_n;
      paper_d = paper_fault_in;
      online_d = online_in;
      fault_n_d = !error_in;
    end
  end

  // acknowledge has its own register: it is the handshake, the rest is status
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_n <= 1'b1;
    end else begin
      ack_n <= ack_n_d;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b1;
      paper_fault <= 1'b0;
      online <= 1'b0;
      fault_n <= 1'b1;
    end else begin
      busy <= busy_d;
      paper_fault <= paper_d;
      online <= online_d;
      fault_n <= fault_n_d;
    end
  end

  // user side handshake
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_ready <= 1'b0;
    end else begin
      // one-cycle pulse; tx_take is a function of tx_valid so handshake holds
      tx_ready <= tx_take && !tx_ready;
    end
  end

  // user side status
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      auto_feed <= 1'b0;
      reverse_mode <= 1'b0;
      host_reset <= 1'b0;
    end else begin
      auto_feed <= !s_sel_n && !s_lf_n;
      reverse_mode <= s_sel_n;
      host_reset <= !s_init_n;
    end
  end
endmodule

// *** logic/pph_pkg.sv ***
// pph_pkg: constants for the peripheral end of a byte-wide parallel printer port.
// assumes a single 10 MHz system clock; all pin timing is counted in its cycles.
package pph_pkg;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 100;
  // ack low pulse and nibble setup, both least times so they round up
  localparam int ACK_PULSE_NS = 500;
  localparam int NIB_SETUP_NS = 200;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ACK_PULSE_CYC =
    CNT_W'((ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] NIB_SETUP_CYC =
    CNT_W'((NIB_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // status line positions inside a returned nibble
  localparam int NIB_FAULT_BIT = 0;
  localparam int NIB_ONLINE_BIT = 1;
  localparam int NIB_PAPER_BIT = 2;
  localparam int NIB_BUSY_BIT = 3;
  typedef enum logic [1:0] {PPH_F_IDLE, PPH_F_ACK, PPH_F_DONE} pph_fwd_e;
  typedef enum logic [2:0] {PPH_R_IDLE, PPH_R_SETUP, PPH_R_ACK, PPH_R_REL, PPH_R_NEXT}
    pph_rev_e;
endpackage

// *** logic/pph_fifo.sv ***
// pph_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module pph_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// *** tb/pph_periph_assertions.sv ***
// pph_periph_assertions: port checks for the parallel port peripheral end.
// assumes one clock with rst_b; bound onto every pph_periph instance.
`timescale 1ns/100ps
module pph_periph_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic strobe_n,
  input wire logic line_feed_req_n,
  input wire logic periph_reset_n,
  input wire logic select_in_n,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic paper_fault,
  input wire logic online,
  input wire logic fault_n,
  input wire logic [pph_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic auto_feed,
  input wire logic host_reset
);
  import pph_pkg::*;
  logic [BYTE_W-1:0] byte_q;
  logic half_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // byte taken for return, and which nibble the next ack low qualifies
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) byte_q <= '0;
    else if (tx_ready) byte_q <= tx_data;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) half_q <= 1'b0;
    else if (tx_ready) half_q <= 1'b0;
    else if (select_in_n && $rose(ack_n)) half_q <= !half_q;
  end
  chk_fwd_ack_len: assert property (
    !select_in_n && $fell(ack_n) |-> (!ack_n && busy) [*3] ##1 (!ack_n) [*2] ##1 ack_n)
    else $error("forward ack pulse wrong");
  chk_strobe_ack: assert property (
    !select_in_n && !busy && $fell(strobe_n) |-> ##[1:5] $fell(ack_n))
    else $error("strobe not acknowledged");
  chk_busy_hold: assert property (
    !select_in_n && !strobe_n && !ack_n |-> busy) else $error("busy low in transfer");
  chk_rev_start: assert property (
    tx_ready |-> $past(tx_valid) && select_in_n ##[1:4] !ack_n)
    else $error("reverse start wrong");
  chk_nib_value: assert property (
    select_in_n && !ack_n && !line_feed_req_n |->
      {busy, paper_fault, online, fault_n} == (half_q ? byte_q[7:4] : byte_q[3:0]))
    else $error("nibble wrong");
  chk_ack_release: assert property (
    select_in_n && !ack_n && $rose(line_feed_req_n) |-> ##[1:5] ack_n)
    else $error("nibble ack stuck");
  chk_reset_busy: assert property (
    (!periph_reset_n && !select_in_n) [*4] |-> busy && host_reset)
    else $error("reset request ignored");
  chk_auto_feed: assert property (
    (!select_in_n && !line_feed_req_n) [*4] |-> auto_feed) else $error("auto feed missed");
  cover property (tx_ready);
  cover property (!select_in_n && $fell(ack_n));
  cover property (select_in_n && half_q && !ack_n);
endmodule
bind pph_periph pph_periph_chk chk_u (.*);

// *** tb/pph_host_model.sv ***
// pph_host_model: host end of the port, strobed bytes out, nibbles back.
// assumes the peripheral under test; hang rises when a wait runs out.
`timescale 1ns/100ps
module pph_host_model (
  input wire logic clock,
  input wire logic ack_n,
  input wire logic busy,
  input wire logic [3:0] nib,
  output logic strobe_n,
  output logic [7:0] fwd_data,
  output logic line_feed_req_n,
  output logic select_in_n,
  output logic periph_reset_n,
  output logic hang,
  output logic [7:0] got,
  output logic got_v
);
  initial begin
    {strobe_n, line_feed_req_n, periph_reset_n} = 3'h7;
    {select_in_n, hang, got_v} = 3'h0;
    fwd_data = 8'h00;
    got = 8'h00;
  end
  // released data lines keep changing so no stale byte can pass
  always @(posedge clock) if (select_in_n) fwd_data <= ~fwd_data;
  task automatic wait_lvl(input int s, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clock);
      if ((s == 0 ? busy : s == 1 ? ack_n : nib[0]) === v) break;
    end
    if (n == 200) hang <= 1'b1;
  endtask
  task automatic set_pins(input logic sel, input logic lf, input logic rst);
    select_in_n <= sel;
    line_feed_req_n <= lf;
    periph_reset_n <= rst;
  endtask
  task automatic send_byte(input logic [7:0] b);
    wait_lvl(0, 1'b0);
    fwd_data <= b;
    repeat (3) @(posedge clock);
    strobe_n <= 1'b0;
    wait_lvl(1, 1'b0);
    strobe_n <= 1'b1;
    @(posedge clock);
    fwd_data <= ~b;
  endtask
  task automatic recv_byte();
    logic [3:0] lo;
    wait_lvl(2, 1'b0);
    line_feed_req_n <= 1'b0;
    wait_lvl(1, 1'b0);
    lo = nib;
    line_feed_req_n <= 1'b1;
    wait_lvl(1, 1'b1);
    line_feed_req_n <= 1'b0;
    wait_lvl(1, 1'b0);
    got <= {nib, lo};
    got_v <= 1'b1;
    line_feed_req_n <= 1'b1;
    wait_lvl(1, 1'b1);
    got_v <= 1'b0;
  endtask
endmodule

// *** tb/pph_periph_tb.sv ***
// pph_periph_tb: self-checking bench for the parallel port peripheral end.
// assumes pph_host_model on the host pins; user side is driven here.
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module pph_periph_tb;
  import pph_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic paper_fault_in = 1'b0;
  logic online_in = 1'b0;
  logic error_in = 1'b0;
  logic [1:0] rx_mode = 2'h0;
  logic [BYTE_W-1:0] tx_data = 8'h00;
  logic [BYTE_W-1:0] rx_data, fwd_data, got, fe, re;
  logic strobe_n, line_feed_req_n, periph_reset_n, select_in_n, hang, got_v;
  logic ack_n, busy, paper_fault, online, fault_n, rx_valid, tx_ready;
  logic auto_feed, reverse_mode, host_reset;
  int seed = 32'h7fe5_86c8;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [BYTE_W-1:0] fq[$];
  logic [BYTE_W-1:0] rq[$];
  pph_periph dut_u (.*);
  pph_host_model host_u (.nib({busy, paper_fault, online, fault_n}), .*);
  initial forever #50 clock = ~clock;
  // mode 1 stalls the reader at random, 2 drains, 0 lets the fifo fill
  always @(posedge clock) rx_ready <= rx_mode[1] | (rx_mode[0] & $random(seed) % 2 != 0);
  always @(posedge clock) if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
    fe = fq.pop_front();
    `CHK(rx_data, fe)
  end
  always @(posedge got_v) begin
    re = rq.pop_front();
    `CHK(got, re)
  end
  always @(posedge hang) fail_out();
  task automatic fail_out();
    n_mismatch++;
    end_sim();
  endtask
  task automatic end_sim();
    $display("%0d mismatches in %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fwd(input int k);
    repeat (k) begin
      fq.push_back(8'($random(seed)));
      host_u.send_byte(fq[$]);
    end
  endtask
  task automatic settle();
    int n;
    for (n = 0; n < 400 && fq.size() + rq.size() > 0; n++) @(posedge clock);
    if (n == 400) fail_out();
  endtask
  task automatic tx_byte(input logic [BYTE_W-1:0] v);
    int n;
    tx_data <= v;
    tx_valid <= 1'b1;
    for (n = 0; n < 200 && tx_ready !== 1'b1; n++) @(posedge clock);
    tx_valid <= 1'b0;
    if (n == 200) fail_out();
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    rx_mode <= 2'h1;
    fwd(10);
    settle();
    $display("forward stream done");
    rx_mode <= 2'h0;
    // the output register holds one byte on top of the fifo
    fwd(FIFO_DEPTH + 1);
    repeat (6) @(posedge clock);
    `CHK({busy, rx_valid}, 2'h3)
    rx_mode <= 2'h2;
    settle();
    repeat (6) @(posedge clock);
    `CHK({busy, rx_valid}, 2'h0)
    $display("fifo fill done");
    for (int i = 0; i < 8; i++) begin
      {paper_fault_in, online_in, error_in} <= i[2:0];
      repeat (5) @(posedge clock);
      `CHK({paper_fault, online, fault_n}, {i[2], i[1], ~i[0]})
    end
    $display("status lines done");
    host_u.set_pins(1'b0, 1'b0, 1'b1);
    repeat (5) @(posedge clock);
    `CHK(auto_feed, 1'b1)
    host_u.set_pins(1'b0, 1'b1, 1'b0);
    repeat (5) @(posedge clock);
    `CHK({host_reset, busy}, 2'h3)
    host_u.set_pins(1'b1, 1'b1, 1'b1);
    repeat (5) @(posedge clock);
    `CHK({host_reset, reverse_mode}, 2'h1)
    $display("host pins done");
    for (int i = 0; i < 4; i++) begin
      rq.push_back(8'($random(seed)));
      fork
        tx_byte(rq[$]);
        host_u.recv_byte();
      join
    end
    settle();
    $display("reverse done");
    end_sim();
  end
endmodule
